/* wake_ctrl_map.svh */
// Address map, field positions, reset values and timing constants of the wake controller
`ifndef WAKE_CTRL_MAP_SVH
`define WAKE_CTRL_MAP_SVH
`define ADDR_IRQ_EN0         11'h100
`define ADDR_IRQ_EN1         11'h101
`define ADDR_COUNT_LO        11'h102
`define ADDR_COUNT_HI        11'h103
`define ADDR_LIMIT_LO        11'h104
`define ADDR_LIMIT_HI        11'h105
`define ADDR_WINDOW          11'h106
`define ADDR_TICK_DIV        11'h107
`define ADDR_LEVEL_LIMIT     11'h108
`define ADDR_OP_CTRL         11'h11a
`define ADDR_CFG_UPPER       11'h30c
`define ADDR_CFG_LOWER       11'h30d
`define ADDR_PERIOD_UPPER    11'h30e
`define ADDR_PERIOD_LOWER    11'h30f
`define RST_BYTE             8'h00
`define RST_WORD             16'h0000
// wake_config_lower fields
`define CFG_RC_EN_BIT        0
`define CFG_XO_EN_BIT        1
`define CFG_SEL_LSB          2
`define CFG_SEL_MSB          3
`define CFG_ARM_BIT          4
`define CFG_RETAIN_BIT       5
// wake_config_upper field
`define CFG_PRESC_MSB        2
// irq_enable_group0 fields
`define IEN0_COUNT_BIT       0
`define IEN0_LEVEL_BIT       1
`define IEN0_PREAMBLE_BIT    2
`define IEN0_SYNC_BIT        3
`define IEN0_ADDR_BIT        4
// irq_enable_group1 field
`define IEN1_TIMEOUT_BIT     0
// operating_control fields
`define OP_LISTEN_BIT        0
`define OP_PREQUAL_BIT       1
// Cause bits as seen on irq_cause
`define CAUSE_TIMEOUT        0
`define CAUSE_COUNT          1
`define CAUSE_LEVEL          2
`define CAUSE_PREAMBLE       3
`define CAUSE_SYNC           4
`define CAUSE_ADDR           5
`define CAUSE_WIDTH          6
// Timing
`define LISTEN_TICK_SHIFT    7
`endif

/* lp_types_pkg.sv */
// Types shared by the wake controller modules
package lp_types_pkg;
    typedef enum logic [2:0] {
        ST_AWAKE   = 3'b000,
        ST_SLEEP   = 3'b001,
        ST_MEASURE = 3'b011,
        ST_LISTEN  = 3'b010,
        ST_HOLD    = 3'b110,
        ST_ON      = 3'b111
    } power_state_t;

    typedef enum logic [1:0] {
        CLK_NONE = 2'b00,
        CLK_RC   = 2'b01,
        CLK_XO   = 2'b10,
        CLK_BAD  = 2'b11
    } wake_clk_sel_t;
endpackage

/* wake_timer_core.sv */
// Prescaled 16-bit down counter that times out and reloads
`timescale 1ns/10ps
`default_nettype none
module wake_timer_core
    import lp_types_pkg::*;
#(
    parameter int COUNT_W = 16,
    parameter int PRESC_W = 3
) (
    input  wire logic               mclk,
    input  wire logic               reset,
    input  wire logic               osc_edge,
    input  wire logic [PRESC_W-1:0] prescale,
    input  wire logic [COUNT_W-1:0] period,
    input  wire logic               load,
    output logic                    timeout,
    output logic      [COUNT_W-1:0] remaining
);
    localparam int DIV_W = 1 << PRESC_W;

    if (COUNT_W < 2 || PRESC_W < 1 || PRESC_W > 4) begin
        $error("wake_timer_core: unsupported width");
    end

    logic [DIV_W-1:0] div_count;
    logic             slow_tick;

    // Terminal count of a divide by 2 to the (prescale + 1)
    function automatic logic [DIV_W-1:0] div_last(input logic [PRESC_W-1:0] p);
        div_last = {DIV_W{1'b1}} >> (DIV_W[PRESC_W:0] - 1'b1 - {1'b0, p});
    endfunction

    assign slow_tick = osc_edge && (div_count == div_last(prescale));

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            div_count <= '0;
        end else if (load || slow_tick) begin
            div_count <= '0; // R05
        end else if (osc_edge) begin
            div_count <= div_count + 1'b1;
        end
    end

    // A zero period never times out, so a cleared timer stays silent
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            remaining <= '0;
            timeout   <= 1'b0;
        end else begin
            timeout <= 1'b0;
            if (load) begin
                remaining <= period;
            end else if (slow_tick && remaining != '0) begin
                if (remaining == {{(COUNT_W-1){1'b0}}, 1'b1}) begin
                    remaining <= period; // R25
                    timeout   <= 1'b1; // R09
                end else begin
                    remaining <= remaining - 1'b1; // R01
                end
            end
        end
    end
endmodule
`default_nettype wire

/* wake_timer_low_power_control.sv */
// Wake timer, wake-up counter and autonomous listen control with byte registers
//
// Behaviour
// R01 - 16-bit wake timer behind programmable prescaler
// R02 - Timer clocked only by slow oscillators
// R03 - Wake-up counter counts every timer timeout while the count interrupt is enabled
// R04 - Retention bit keeps backup RAM through sleep
// R05 - 3-bit prescaler field sets oscillator division
// R06 - Separate enables for RC and crystal oscillators
// R07 - Clock select: 1 RC, 2 crystal
// R08 - Armed timeout wakes device from sleep
// R09 - Interval is period times 2^(p+1)/32768
// R10 - Timeout interrupt enable in group 1
// R11 - Count interrupt enable also enables counter
// R12 - Count above limit leaves low power
// R13 - Listen enable wakes device autonomously
// R14 - Second control bit enables level prequalification
// R15 - Level limit register sets prequal threshold
// R16 - Dwell equals window count of ticks
// R17 - Divider sets dwell tick rate
// R18 - Host writes config upper then lower
// R19 - Host writes period upper then lower
// R20 - Listen event enables gate their interrupts
// R21 - Enabled listen events wake sleeping host
// R22 - Timeout adds one, raises enabled interrupt
// R23 - Count within limit returns to sleep
// R24 - Preamble in window extends dwell to end
// R25 - Timer reloads period and restarts
// R26 - Level compared only when prequal enabled
`timescale 1ns/10ps
`default_nettype none
`include "wake_ctrl_map.svh"
module wake_timer_low_power_control
    import lp_types_pkg::*;
#(
    parameter int COUNT_W = 16
) (
    input  wire logic        mclk,
    input  wire logic        reset,
    input  wire logic [10:0] reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    input  wire logic        rc_osc_32k,
    input  wire logic        crystal_osc_32k,
    input  wire logic        dwell_ref_6m5,
    input  wire logic        sleep_cmd,
    input  wire logic        wake_cmd,
    input  wire logic        level_valid,
    input  wire logic [7:0]  level_sample,
    input  wire logic        preamble_seen,
    input  wire logic        sync_seen,
    input  wire logic        address_seen,
    input  wire logic        packet_done,
    input  wire logic        packet_invalid,
    input  wire logic        irq_ack,
    output logic             rc_osc_enable,
    output logic             crystal_osc_enable,
    output logic             sleep_state,
    output logic             backup_ram_keep,
    output logic             radio_rx_on,
    output logic             host_irq,
    output logic      [5:0]  irq_cause
);
    if (COUNT_W != 16) begin
        $error("wake_timer_low_power_control: counter must be 16 bits");
    end

    power_state_t state;
    power_state_t next_state;

    logic [7:0]  irq_enable_group0;
    logic [7:0]  irq_enable_group1;
    logic [15:0] wake_count;
    logic [15:0] wake_count_limit;
    logic [7:0]  listen_window_count;
    logic [7:0]  listen_tick_div;
    logic [7:0]  level_prequal_limit;
    logic [7:0]  operating_control;
    logic [7:0]  wake_config_upper;
    logic [7:0]  wake_config_lower;
    logic [7:0]  staged_config_upper;
    logic [15:0] wake_period_count;
    logic [7:0]  staged_period_upper;
    logic        period_load;

    logic        wr_hit_cfg_lo;
    logic        wr_hit_per_lo;
    logic        timeout;
    logic [15:0] remaining;
    logic        osc_sel_level;
    logic        osc_prev;
    logic        osc_edge;
    logic        ref_prev;
    logic        ref_edge;
    logic [14:0] tick_count;
    logic [7:0]  window_left;
    logic        window_over;
    logic        count_on;
    logic [15:0] count_plus;
    logic        count_exceeds;
    logic [5:0]  cause_set;

    function automatic logic wr_at(input logic [10:0] a);
        wr_at = reg_wr && (reg_addr == a);
    endfunction

    assign wr_hit_cfg_lo = wr_at(`ADDR_CFG_LOWER);
    assign wr_hit_per_lo = wr_at(`ADDR_PERIOD_LOWER);
    assign count_on      = irq_enable_group0[`IEN0_COUNT_BIT]; // R11
    assign count_plus    = wake_count + 16'h0001;
    assign count_exceeds = count_plus > wake_count_limit; // R12

    // Register writes; config and period upper bytes wait in staging until their lower partner arrives
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            irq_enable_group0   <= `RST_BYTE;
            irq_enable_group1   <= `RST_BYTE;
            wake_count_limit    <= `RST_WORD;
            listen_window_count <= `RST_BYTE;
            listen_tick_div     <= `RST_BYTE;
            level_prequal_limit <= `RST_BYTE;
            operating_control   <= `RST_BYTE;
            staged_config_upper <= `RST_BYTE;
            wake_config_upper   <= `RST_BYTE;
            wake_config_lower   <= `RST_BYTE;
            staged_period_upper <= `RST_BYTE;
            wake_period_count   <= `RST_WORD;
        end else if (reg_wr) begin
            unique case (reg_addr)
                `ADDR_IRQ_EN0:      irq_enable_group0      <= reg_wdata;
                `ADDR_IRQ_EN1:      irq_enable_group1      <= reg_wdata;
                `ADDR_LIMIT_LO:     wake_count_limit[7:0]  <= reg_wdata;
                `ADDR_LIMIT_HI:     wake_count_limit[15:8] <= reg_wdata;
                `ADDR_WINDOW:       listen_window_count    <= reg_wdata;
                `ADDR_TICK_DIV:     listen_tick_div        <= reg_wdata;
                `ADDR_LEVEL_LIMIT:  level_prequal_limit    <= reg_wdata;
                `ADDR_OP_CTRL:      operating_control      <= reg_wdata;
                `ADDR_CFG_UPPER:    staged_config_upper    <= reg_wdata;
                `ADDR_CFG_LOWER: begin
                    wake_config_upper <= staged_config_upper; // R18
                    wake_config_lower <= reg_wdata;
                end
                `ADDR_PERIOD_UPPER: staged_period_upper    <= reg_wdata;
                `ADDR_PERIOD_LOWER: wake_period_count <= {staged_period_upper, reg_wdata}; // R19
                default: ;
            endcase
        end
    end

    // Timer restarts whenever its period or configuration is committed
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            period_load <= 1'b0;
        end else begin
            period_load <= wr_hit_per_lo || wr_hit_cfg_lo;
        end
    end

    // Slow clock source; a source that is not switched on gives no edges
    always_comb begin
        unique case (wake_clk_sel_t'(wake_config_lower[`CFG_SEL_MSB:`CFG_SEL_LSB]))
            CLK_RC:   osc_sel_level = rc_osc_32k && wake_config_lower[`CFG_RC_EN_BIT]; // R07
            CLK_XO:   osc_sel_level = crystal_osc_32k && wake_config_lower[`CFG_XO_EN_BIT]; // R07
            CLK_NONE: osc_sel_level = 1'b0;
            CLK_BAD:  osc_sel_level = 1'b0;
        endcase
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            osc_prev <= 1'b0;
            ref_prev <= 1'b0;
        end else begin
            osc_prev <= osc_sel_level;
            ref_prev <= dwell_ref_6m5;
        end
    end

    assign osc_edge = osc_sel_level && !osc_prev; // R02
    assign ref_edge = dwell_ref_6m5 && !ref_prev;

    wake_timer_core #(
        .COUNT_W (COUNT_W),
        .PRESC_W (3)
    ) u_timer (
        .mclk      (mclk),
        .reset     (reset),
        .osc_edge  (osc_edge),
        .prescale  (wake_config_upper[`CFG_PRESC_MSB:0]),
        .period    (wake_period_count),
        .load      (period_load),
        .timeout   (timeout),
        .remaining (remaining)
    );

    // Wake-up counter; host writes lose to a coincident timeout while the count interrupt is enabled
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            wake_count <= `RST_WORD;
        end else if (timeout && count_on) begin
            wake_count <= count_plus; // R03 R22
        end else if (wr_at(`ADDR_COUNT_LO)) begin
            wake_count[7:0] <= reg_wdata;
        end else if (wr_at(`ADDR_COUNT_HI)) begin
            wake_count[15:8] <= reg_wdata;
        end
    end

    // Dwell window: each tick is 128 times the divider in reference edges
    assign window_over = (window_left == 8'h00) || (listen_tick_div == 8'h00);

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            tick_count  <= 15'h0000;
            window_left <= `RST_BYTE;
        end else if (state != ST_LISTEN) begin
            tick_count  <= 15'h0000;
            window_left <= listen_window_count; // R16
        end else if (ref_edge && !window_over) begin
            if (tick_count == (15'(listen_tick_div) << `LISTEN_TICK_SHIFT) - 15'h0001) begin
                tick_count  <= 15'h0000;
                window_left <= window_left - 8'h01; // R17
            end else begin
                tick_count <= tick_count + 15'h0001;
            end
        end
    end

    // Power state sequencing
    always_comb begin
        next_state = state;
        unique case (state)
            ST_AWAKE, ST_ON: begin
                if (sleep_cmd) begin
                    next_state = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (wake_cmd) begin
                    next_state = ST_AWAKE;
                end else if (timeout && wake_config_lower[`CFG_ARM_BIT]) begin // R08
                    if (count_on && count_exceeds) begin
                        next_state = ST_AWAKE; // R12
                    end else if (!operating_control[`OP_LISTEN_BIT]) begin
                        next_state = ST_SLEEP; // R23
                    end else if (operating_control[`OP_PREQUAL_BIT]) begin // R14
                        next_state = ST_MEASURE; // R13
                    end else begin
                        next_state = ST_LISTEN; // R26
                    end
                end
            end
            ST_MEASURE: begin
                if (wake_cmd) begin
                    next_state = ST_AWAKE;
                end else if (level_valid) begin
                    if (level_sample <= level_prequal_limit) begin // R15
                        next_state = ST_SLEEP;
                    end else if (irq_enable_group0[`IEN0_LEVEL_BIT]) begin
                        next_state = ST_ON;
                    end else begin
                        next_state = ST_LISTEN; // R26
                    end
                end
            end
            ST_LISTEN, ST_HOLD: begin
                if (wake_cmd) begin
                    next_state = ST_AWAKE;
                end else if (cause_set[`CAUSE_PREAMBLE] || cause_set[`CAUSE_SYNC]
                             || cause_set[`CAUSE_ADDR]) begin
                    next_state = ST_ON; // R21
                end else if (packet_invalid) begin
                    next_state = ST_SLEEP;
                end else if (packet_done && state == ST_HOLD) begin
                    next_state = ST_ON;
                end else if (preamble_seen && state == ST_LISTEN) begin
                    next_state = ST_HOLD; // R24
                end else if (state == ST_LISTEN && window_over) begin
                    next_state = ST_SLEEP;
                end
            end
            default: next_state = ST_AWAKE;
        endcase
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            state <= ST_AWAKE;
        end else begin
            state <= next_state;
        end
    end

    // Interrupt causes; level counts in measure, preamble in listen, sync and address in listen or hold
    always_comb begin
        cause_set = '0;
        cause_set[`CAUSE_TIMEOUT] = timeout && irq_enable_group1[`IEN1_TIMEOUT_BIT]; // R10 R22
        cause_set[`CAUSE_COUNT] = timeout && count_on && count_exceeds; // R11
        cause_set[`CAUSE_LEVEL] = state == ST_MEASURE && level_valid
                                  && level_sample > level_prequal_limit
                                  && irq_enable_group0[`IEN0_LEVEL_BIT]; // R20
        cause_set[`CAUSE_PREAMBLE] = state == ST_LISTEN && preamble_seen
                                     && irq_enable_group0[`IEN0_PREAMBLE_BIT]; // R20
        cause_set[`CAUSE_SYNC] = (state == ST_LISTEN || state == ST_HOLD) && sync_seen
                                 && irq_enable_group0[`IEN0_SYNC_BIT]; // R20
        cause_set[`CAUSE_ADDR] = (state == ST_LISTEN || state == ST_HOLD) && address_seen
                                 && irq_enable_group0[`IEN0_ADDR_BIT]; // R20
    end

    // Set wins over the acknowledge so no event slips through
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            irq_cause <= '0;
            host_irq  <= 1'b0;
        end else begin
            irq_cause <= (irq_ack ? 6'h00 : irq_cause) | cause_set; // R21
            host_irq  <= (!irq_ack && host_irq) || (cause_set != 6'h00); // R21
        end
    end

    // Sleep, RAM and receiver outputs follow the next state so they change with it; oscillator enables follow wake_config_lower
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            sleep_state        <= 1'b0;
            backup_ram_keep    <= 1'b1;
            radio_rx_on        <= 1'b0;
            rc_osc_enable      <= 1'b0;
            crystal_osc_enable <= 1'b0;
        end else begin
            sleep_state        <= next_state == ST_SLEEP;
            backup_ram_keep    <= next_state != ST_SLEEP
                                  || wake_config_lower[`CFG_RETAIN_BIT]; // R04
            radio_rx_on        <= next_state == ST_MEASURE || next_state == ST_LISTEN
                                  || next_state == ST_HOLD;
            rc_osc_enable      <= wake_config_lower[`CFG_RC_EN_BIT]; // R06
            crystal_osc_enable <= wake_config_lower[`CFG_XO_EN_BIT]; // R06
        end
    end

    // Read port: one cycle late, unmapped addresses read zero
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            reg_rdata <= `RST_BYTE;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `ADDR_IRQ_EN0:      reg_rdata <= irq_enable_group0;
                `ADDR_IRQ_EN1:      reg_rdata <= irq_enable_group1;
                `ADDR_COUNT_LO:     reg_rdata <= wake_count[7:0];
                `ADDR_COUNT_HI:     reg_rdata <= wake_count[15:8];
                `ADDR_LIMIT_LO:     reg_rdata <= wake_count_limit[7:0];
                `ADDR_LIMIT_HI:     reg_rdata <= wake_count_limit[15:8];
                `ADDR_WINDOW:       reg_rdata <= listen_window_count;
                `ADDR_TICK_DIV:     reg_rdata <= listen_tick_div;
                `ADDR_LEVEL_LIMIT:  reg_rdata <= level_prequal_limit;
                `ADDR_OP_CTRL:      reg_rdata <= operating_control;
                `ADDR_CFG_UPPER:    reg_rdata <= wake_config_upper;
                `ADDR_CFG_LOWER:    reg_rdata <= wake_config_lower;
                `ADDR_PERIOD_UPPER: reg_rdata <= wake_period_count[15:8];
                `ADDR_PERIOD_LOWER: reg_rdata <= wake_period_count[7:0];
                default:            reg_rdata <= `RST_BYTE;
            endcase
        end
    end
endmodule
`default_nettype wire

/* host_bus_model.sv */
// Host model driving the byte register bus of the wake controller
`timescale 1ns/10ps
`default_nettype none
module host_bus_model (
    input  wire logic        mclk,
    input  wire logic [7:0]  reg_rdata,
    output logic      [10:0] reg_addr,
    output logic      [7:0]  reg_wdata,
    output logic             reg_wr,
    output logic             reg_rd
);
    initial begin
        {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
    end
    task automatic wr(input logic [10:0] a, input logic [7:0] d);
        @(negedge mclk);
        {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
        @(negedge mclk);
        // Released lines show the inverse, not a stale value
        {reg_addr, reg_wdata, reg_wr} = {~a, ~d, 1'b0};
    endtask
    task automatic rd(input logic [10:0] a, output logic [7:0] d);
        @(negedge mclk);
        {reg_addr, reg_rd} = {a, 1'b1};
        @(negedge mclk);
        {reg_addr, reg_rd} = {~a, 1'b0};
        @(negedge mclk);
        d = reg_rdata;
    endtask
    // Upper byte first, lower straight after: the lower write commits both
    task automatic wr_pair(input logic [10:0] a, input logic [15:0] v);
        wr(a, v[15:8]);
        wr(a + 11'h001, v[7:0]);
    endtask
endmodule
`default_nettype wire

/* wake_ctrl_checker.sv */
// Port-level assertions for the wake controller
`timescale 1ns/10ps
`default_nettype none
module wake_ctrl_checker (
    input wire logic        mclk,
    input wire logic        reset,
    input wire logic [10:0] reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_wr,
    input wire logic        sleep_cmd,
    input wire logic        wake_cmd,
    input wire logic        level_valid,
    input wire logic        preamble_seen,
    input wire logic        irq_ack,
    input wire logic        rc_osc_enable,
    input wire logic        crystal_osc_enable,
    input wire logic        sleep_state,
    input wire logic        backup_ram_keep,
    input wire logic        radio_rx_on,
    input wire logic        host_irq,
    input wire logic [5:0]  irq_cause
);
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    sequence cfg_write;
        reg_wr && reg_addr == 11'h30d;
    endsequence
    sequence irq_raise;
        !host_irq ##1 host_irq;
    endsequence
    rc_enable_copy_a: assert property (cfg_write |->
        ##2 rc_osc_enable == $past(reg_wdata[0], 2)) else $error("rc enable wrong");
    xo_enable_copy_a: assert property (cfg_write |->
        ##2 crystal_osc_enable == $past(reg_wdata[1], 2)) else $error("xo enable wrong");
    ram_keep_a: assert property (!sleep_state |-> backup_ram_keep)
        else $error("backup ram dropped while awake");
    rx_sleep_excl_a: assert property (radio_rx_on |-> !sleep_state)
        else $error("receiver on while asleep");
    sleep_entry_a: assert property (sleep_cmd && !sleep_state && !radio_rx_on |=>
        sleep_state) else $error("sleep not entered");
    wake_exit_a: assert property (wake_cmd && (sleep_state || radio_rx_on) |=>
        !sleep_state && !radio_rx_on) else $error("wake command ignored");
    irq_cause_a: assert property (irq_raise |-> irq_cause != 6'h00)
        else $error("interrupt without cause");
    irq_hold_a: assert property (host_irq && !irq_ack |=> host_irq)
        else $error("interrupt dropped without ack");
    irq_clear_a: assert property ($fell(host_irq) |-> $past(irq_ack))
        else $error("interrupt cleared without ack");
    level_cause_a: assert property ($rose(irq_cause[2]) |->
        $past(level_valid) || $past(level_valid, 2)) else $error("level cause unprompted");
    preamble_cause_a: assert property ($rose(irq_cause[3]) |->
        $past(preamble_seen) || $past(preamble_seen, 2)) else $error("preamble cause unprompted");
endmodule
`default_nettype wire

/* wake_timer_low_power_control_tb_top.sv */
// Self-checking bench for the wake controller
`timescale 1ns/10ps
`default_nettype none
module wake_timer_low_power_control_tb_top;
    typedef struct packed {
        logic [10:0] addr;
        logic [7:0]  wdata;
        logic [7:0]  exp;
    } row_t;
    logic        mclk, reset, reg_wr, reg_rd, rc_osc_32k, crystal_osc_32k, dwell_ref_6m5;
    logic        sleep_cmd, wake_cmd, level_valid, preamble_seen, sync_seen, address_seen;
    logic        packet_done, packet_invalid, irq_ack, rc_osc_enable, crystal_osc_enable;
    logic        sleep_state, backup_ram_keep, radio_rx_on, host_irq, osc_run;
    logic [10:0] reg_addr;
    logic [7:0]  reg_wdata, reg_rdata, level_sample, rdv, rdh;
    logic [5:0]  irq_cause;
    logic [1:0]  div_cnt;
    logic [15:0] osc_edges;
    int          err_count, samples_checked;
    // Count 0x00ff, limit 0x0100: the second timeout exceeds
    row_t rows [11] = '{'{11'h100, 8'h1f, 8'h1f}, '{11'h101, 8'h01, 8'h01},
        '{11'h102, 8'hff, 8'hff}, '{11'h103, 8'h00, 8'h00}, '{11'h104, 8'h00, 8'h00},
        '{11'h105, 8'h01, 8'h01}, '{11'h106, 8'h01, 8'h01}, '{11'h107, 8'h01, 8'h01},
        '{11'h108, 8'h40, 8'h40}, '{11'h11a, 8'h00, 8'h00}, '{11'h109, 8'h77, 8'h00}};
    host_bus_model i_host (.*);
    wake_timer_low_power_control i_dut (.*);
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    // Slow oscillator: period 8 cycles, runs only while osc_run
    always @(negedge mclk) begin
        div_cnt <= div_cnt + 2'd1;
        dwell_ref_6m5 <= ~dwell_ref_6m5;
        if (osc_run && div_cnt == 2'd3) begin
            rc_osc_32k <= ~rc_osc_32k;
            if (!rc_osc_32k) osc_edges <= osc_edges + 16'd1;
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        if (err_count == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic wait_for(input int k);
        for (int n = 0; !(k == 0 ? host_irq : k == 1 ? !sleep_state : radio_rx_on); n++) begin
            if (n == 3000) begin
                err_count++;
                final_report();
            end
            @(negedge mclk);
        end
    endtask
    task automatic pulse(input int k);
        @(negedge mclk);
        case (k)
            0: sleep_cmd = 1'b1;
            1: wake_cmd = 1'b1;
            2: irq_ack = 1'b1;
            3: level_valid = 1'b1;
            default: preamble_seen = 1'b1;
        endcase
        @(negedge mclk);
        {sleep_cmd, wake_cmd, irq_ack, level_valid, preamble_seen} = 5'h00;
    endtask
    task automatic nap();
        pulse(2);
        if (!sleep_state) pulse(0);
        osc_run <= 1'b1;
        wait_for(2);
        osc_run <= 1'b0;
    endtask
    initial begin
        reset = 1'b1;
        {osc_run, div_cnt, osc_edges, err_count, samples_checked, packet_invalid, irq_ack} = '0;
        {rc_osc_32k, crystal_osc_32k, dwell_ref_6m5, sleep_cmd, wake_cmd, level_valid} = '0;
        {level_sample, preamble_seen, sync_seen, address_seen, packet_done} = '0;
        repeat (10) @(negedge mclk);
        reset = 1'b0;
        foreach (rows[i]) begin
            i_host.rd(rows[i].addr, rdv);
            chk(rdv, 8'h00);
            i_host.wr(rows[i].addr, rows[i].wdata);
            i_host.rd(rows[i].addr, rdv);
            chk(rdv, rows[i].exp);
        end
        i_host.wr_pair(11'h30c, 16'h0035);
        i_host.wr_pair(11'h30e, 16'h0003);
        i_host.rd(11'h30d, rdv);
        chk({rdv, rc_osc_enable, crystal_osc_enable}, {8'h35, 2'b10});
        pulse(0);
        osc_run <= 1'b1;
        wait_for(0);
        chk(osc_edges, 16'd3 * (16'd1 << 1));
        chk({sleep_state, backup_ram_keep, irq_cause}, 8'hc1);
        pulse(2);
        i_host.rd(11'h102, rdv);
        i_host.rd(11'h103, rdh);
        chk({host_irq, rdh, rdv}, 17'h00100);
        wait_for(1);
        osc_run <= 1'b0;
        chk(osc_edges, 16'd12);
        chk({sleep_state, irq_cause}, 7'h03);
        i_host.wr(11'h11a, 8'h03);
        i_host.wr(11'h100, 8'h02);
        for (int k = 0; k < 2; k++) begin
            nap();
            level_sample = 8'h40 + k[7:0];
            pulse(3);
            @(negedge mclk);
            chk({sleep_state, host_irq, irq_cause[2]}, k ? 3'b011 : 3'b110);
        end
        i_host.wr(11'h11a, 8'h01);
        i_host.wr(11'h100, 8'h04);
        nap();
        repeat (200) @(negedge mclk);
        chk(radio_rx_on, 1'b1);
        repeat (100) @(negedge mclk);
        chk({radio_rx_on, sleep_state}, 2'b01);
        nap();
        pulse(1);
        chk({sleep_state, radio_rx_on}, 2'b00);
        nap();
        pulse(4);
        @(negedge mclk);
        chk({radio_rx_on, irq_cause}, 7'h09);
        final_report();
    end
endmodule
bind wake_timer_low_power_control wake_ctrl_checker i_chk (.*);
`default_nettype wire
